// ### rtl/iucp_pkg.sv
`default_nettype none
package iucp_pkg;
	// Clock and serial rate
	localparam int CLK_HZ = 50_000_000;
	localparam int BAUD = 460_800;
	localparam int BIT_CYC_DEF = CLK_HZ / BAUD;
	// Power-up wait before the first command
	localparam int POWER_UP_MS = 800;
	localparam int POWER_UP_CYC = (CLK_HZ / 1000) * POWER_UP_MS;
	// Sample rate of the frame timer
	localparam int SAMPLE_SPS = 125;
	localparam int SAMPLE_CYC_DEF = CLK_HZ / SAMPLE_SPS;
	// Words a sample frame may carry
	localparam int NWORDS = 17;
	// Frame bytes and command values
	localparam logic [7:0] TERM_BYTE = 8'h0d;
	localparam logic [7:0] WIN_SEL = 8'hfe;
	localparam logic [7:0] BURST_CMD = 8'h80;
	localparam logic [7:0] MODE_GO_SAMPLE = 8'h01;
	localparam logic [7:0] MODE_GO_CFG = 8'h02;
	localparam logic [7:0] CFG_MODE_UPPER = 8'h04;
	// Register addresses, write flag stripped
	localparam logic [6:0] A_MODE = 7'h02;
	localparam logic [6:0] A_MODE_CTRL = 7'h03;
	localparam logic [6:0] A_DIAG = 7'h04;
	localparam logic [6:0] A_SER = 7'h08;
	localparam logic [6:0] A_GLOB = 7'h0a;
	localparam logic [6:0] A_BC1 = 7'h0c;
	localparam logic [6:0] A_BC2 = 7'h0d;
	localparam logic [6:0] A_BCFG_WORD = 7'h0e;
	localparam logic [6:0] A_BCFG = 7'h0f;
	// Field positions
	localparam int NOT_READY_BIT = 10;
	localparam int HW_FAULT_LSB = 5;
	localparam int SER_AUTO = 0;
	localparam int BC1_COUNT = 1;
	localparam int BC1_GPIO = 2;
	localparam int BC2_ACCL = 4;
	localparam int BC2_GYRO = 5;
	localparam int BC2_TEMP = 6;
	localparam int BC2_FLAG = 7;
	localparam int BCF_ACCL32 = 4;
	localparam int BCF_GYRO32 = 5;
	localparam int BCF_TEMP32 = 6;
	// Reset values
	localparam logic [7:0] SER_RST = 8'h00;
	localparam logic [7:0] BC1_RST = 8'h00;
	localparam logic [7:0] BC2_RST = 8'h00;
	localparam logic [7:0] BCF_RST = 8'h00;
	// Host controller registers on APB
	localparam logic [11:0] H_CMD = 12'h000;
	localparam logic [11:0] H_STAT = 12'h004;
	localparam logic [11:0] H_RDATA = 12'h008;
	localparam logic [11:0] H_RXBYTE = 12'h00c;
	localparam logic [11:0] H_IRQ_STAT = 12'h010;
	localparam logic [11:0] H_IRQ_MASK = 12'h014;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_RX = 1;
	localparam int IRQ_DRDY = 2;
endpackage
`default_nettype wire

// ### rtl/iucp_link.sv
`timescale 1ns/1ps
`default_nettype none
interface iucp_link;
	logic h2d;
	logic d2h;
	logic drdy;
	modport dev (input h2d, output d2h, output drdy);
	modport host (output h2d, input d2h, input drdy);
endinterface
`default_nettype wire

// ### rtl/iucp_device.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Host waits 800 ms after power-up
// - Not-ready flag, global command bit 10
// - Hardware fault field, diagnostic bits 6:5
// - Write to 0xFE selects register window
// - Read frame: address, zero, terminator
// - Read reply: address, MSB, LSB, terminator
// - Mode register upper byte 0x04 in configuration
// - Write frame: address with bit 7, data, terminator
// - Register writes get no reply
// - Mode control 0x01 starts sampling
// - Mode control 0x02 returns to configuration
// - Automatic mode sends one frame per period
// - Manual burst: 0x80 frame, reply with words
// - Host waits for data-ready before burst
// - Control 0x0C adds GPIO and counter words
// - Control 0x0D adds flag, temp, gyro, accel
// - Config 0x0F selects 32-bit words, high first
// - Config 0x00 sends upper words only
module iucp_device #(
	parameter int STARTUP_CYC = iucp_pkg::POWER_UP_CYC,
	parameter int SAMPLE_CYC = iucp_pkg::SAMPLE_CYC_DEF,
	parameter int BIT_CYC = iucp_pkg::BIT_CYC_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Serial link
	iucp_link.dev link,
	// Sensor side
	input wire logic [iucp_pkg::NWORDS-1:0][15:0] sample_words,
	input wire logic [1:0] hw_fault,
	output logic sampling
);
	import iucp_pkg::*;

	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_HEAD = 3'b001,
		T_HI = 3'b011,
		T_LO = 3'b010,
		T_TERM = 3'b110
	} iucp_tx_e;

	if (BIT_CYC < 4 || BIT_CYC > 65535 || SAMPLE_CYC < 2 || STARTUP_CYC < 1) begin : g_chk
		$error("iucp_device: unsupported timing parameter");
	end

	localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
	localparam logic [15:0] HALF = 16'(BIT_CYC / 2 - 1);

	function automatic logic word_en(input logic [4:0] idx, input logic [7:0] c1,
		input logic [7:0] c2, input logic [7:0] cf);
		case (idx)
			5'd0: return c2[BC2_FLAG];
			5'd1: return c2[BC2_TEMP];
			5'd2: return c2[BC2_TEMP] & cf[BCF_TEMP32];
			5'd3, 5'd5, 5'd7: return c2[BC2_GYRO];
			5'd4, 5'd6, 5'd8: return c2[BC2_GYRO] & cf[BCF_GYRO32];
			5'd9, 5'd11, 5'd13: return c2[BC2_ACCL];
			5'd10, 5'd12, 5'd14: return c2[BC2_ACCL] & cf[BCF_ACCL32];
			5'd15: return c1[BC1_GPIO];
			5'd16: return c1[BC1_COUNT];
			default: return 1'b0;
		endcase
	endfunction

	// First enabled word at or after from; NWORDS when none is left
	function automatic logic [4:0] next_en(input logic [4:0] from, input logic [7:0] c1,
		input logic [7:0] c2, input logic [7:0] cf);
		logic [4:0] r;
		r = 5'(NWORDS);
		for (int i = NWORDS - 1; i >= 0; i--) begin
			if (5'(i) >= from && word_en(5'(i), c1, c2, cf)) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic [1:0] rx_meta;
	logic [1:0] fault_meta;
	logic [1:0] fault_s;
	logic rx_busy;
	logic rx_valid;
	logic [3:0] rx_bit;
	logic [15:0] rx_cnt;
	logic [7:0] rx_sh;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta <= 2'h3;
			fault_meta <= 2'h0;
			fault_s <= 2'h0;
		end else begin
			rx_meta <= {rx_meta[0], link.h2d};
			fault_meta <= hw_fault;
			fault_s <= fault_meta;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_busy <= 1'b0;
			rx_valid <= 1'b0;
			rx_bit <= 4'h0;
			rx_cnt <= 16'h0;
			rx_sh <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_busy) begin
				if (!rx_meta[1]) begin
					rx_busy <= 1'b1;
					rx_cnt <= HALF;
					rx_bit <= 4'h0;
				end
			end else if (rx_cnt != 16'h0) begin
				rx_cnt <= rx_cnt - 16'h1;
			end else begin
				rx_cnt <= FULL;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0 && rx_meta[1]) begin
					rx_busy <= 1'b0;
				end else if (rx_bit == 4'h9) begin
					rx_busy <= 1'b0;
					rx_valid <= rx_meta[1];
				end else if (rx_bit != 4'h0) begin
					rx_sh <= {rx_meta[1], rx_sh[7:1]};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Three-byte command frames; a bad terminator drops the frame
	logic [1:0] fcnt;
	logic [7:0] faddr;
	logic [7:0] fdata;
	logic cmd_go;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fcnt <= 2'h0;
			faddr <= 8'h00;
			fdata <= 8'h00;
			cmd_go <= 1'b0;
		end else begin
			cmd_go <= 1'b0;
			if (rx_valid) begin
				case (fcnt)
					2'h0: begin
						faddr <= rx_sh;
						fcnt <= 2'h1;
					end
					2'h1: begin
						fdata <= rx_sh;
						fcnt <= 2'h2;
					end
					default: begin
						fcnt <= 2'h0;
						cmd_go <= (rx_sh == TERM_BYTE);
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic window;
	logic not_ready;
	logic drdy_q;
	logic tick;
	logic [7:0] ser;
	logic [7:0] bc1;
	logic [7:0] bc2;
	logic [7:0] bcf;
	logic [31:0] nr_cnt;
	logic [31:0] s_cnt;
	iucp_tx_e st;

	wire tx_idle;
	wire wr_win = cmd_go && faddr == WIN_SEL;
	wire wr_any = cmd_go && faddr[7] && !wr_win && faddr != BURST_CMD;
	wire wr_w0 = wr_any && !window;
	wire wr_w1 = wr_any && window;
	wire wr_mode = wr_w0 && faddr[6:0] == A_MODE_CTRL;
	wire do_read = cmd_go && !faddr[7];
	wire do_burst = cmd_go && faddr == BURST_CMD && sampling && !ser[SER_AUTO];
	wire auto_go = tick && ser[SER_AUTO];
	wire start_rd = do_read && tx_idle;
	wire start_frm = (do_burst || auto_go) && tx_idle;
	wire [7:0] mode_hi = sampling ? 8'h00 : CFG_MODE_UPPER;
	wire [15:0] rd_w0 =
		(faddr[6:0] == A_MODE) ? {mode_hi, 8'h00} :
		(faddr[6:0] == A_DIAG) ? 16'(fault_s) << HW_FAULT_LSB : 16'h0000;
	wire [15:0] rd_w1 =
		(faddr[6:0] == A_GLOB) ? 16'(not_ready) << NOT_READY_BIT :
		(faddr[6:0] == A_SER) ? {8'h00, ser} :
		(faddr[6:0] == A_BC1) ? {bc2, bc1} :
		(faddr[6:0] == A_BCFG_WORD) ? {bcf, 8'h00} : 16'h0000;
	wire [15:0] rd_word = window ? rd_w1 : rd_w0;

	assign tick = sampling && s_cnt == 32'(SAMPLE_CYC - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			window <= 1'b0;
			sampling <= 1'b0;
			ser <= SER_RST;
			bc1 <= BC1_RST;
			bc2 <= BC2_RST;
			bcf <= BCF_RST;
		end else begin
			if (wr_win) window <= fdata[0];
			if (wr_mode && fdata == MODE_GO_SAMPLE) sampling <= 1'b1;
			if (wr_mode && fdata == MODE_GO_CFG) sampling <= 1'b0;
			if (wr_w1 && faddr[6:0] == A_SER) ser <= fdata;
			if (wr_w1 && faddr[6:0] == A_BC1) bc1 <= fdata;
			if (wr_w1 && faddr[6:0] == A_BC2) bc2 <= fdata;
			if (wr_w1 && faddr[6:0] == A_BCFG) bcf <= fdata;
		end
	end

	// Start-up time and the sample period; data-ready falls when a burst starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			not_ready <= 1'b1;
			nr_cnt <= 32'h0;
			s_cnt <= 32'h0;
			drdy_q <= 1'b0;
		end else begin
			if (not_ready) nr_cnt <= nr_cnt + 32'h1;
			if (not_ready && nr_cnt >= 32'(STARTUP_CYC - 1)) not_ready <= 1'b0;
			s_cnt <= (!sampling || tick) ? 32'h0 : s_cnt + 32'h1;
			if (!sampling || (start_frm && do_burst)) drdy_q <= 1'b0;
			else if (tick) drdy_q <= 1'b1;
		end
	end

	assign link.drdy = drdy_q;

	////////////////////////////////////////////////////////////////////////////
	// Reply sequencer and serializer; sample words are frozen at frame start
	logic kind;
	logic tx_busy;
	logic d2h_q;
	logic [7:0] head;
	logic [15:0] rd_val;
	logic [4:0] widx;
	logic [3:0] tx_bit;
	logic [15:0] tx_cnt;
	logic [8:0] tx_sh;
	logic [NWORDS-1:0][15:0] snap;

	wire [15:0] cur_word = kind ? snap[widx] : rd_val;
	wire [4:0] first_idx = next_en(5'h0, bc1, bc2, bcf);
	wire [4:0] nxt_idx = next_en(widx + 5'h1, bc1, bc2, bcf);
	wire [7:0] tx_byte =
		(st == T_HEAD) ? head :
		(st == T_HI) ? cur_word[15:8] :
		(st == T_LO) ? cur_word[7:0] : TERM_BYTE;
	assign tx_idle = st == T_IDLE && !tx_busy;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= T_IDLE;
			kind <= 1'b0;
			head <= 8'h00;
			rd_val <= 16'h0000;
			widx <= 5'h0;
			snap <= '0;
		end else if (start_rd || start_frm) begin
			// Writes never start a reply
			st <= T_HEAD;
			kind <= start_frm;
			head <= start_frm ? BURST_CMD : faddr;
			rd_val <= rd_word;
			widx <= first_idx;
			snap <= sample_words;
		end else if (st != T_IDLE && !tx_busy) begin
			case (st)
				T_HEAD: st <= (kind && first_idx == 5'(NWORDS)) ? T_TERM : T_HI;
				T_HI: st <= T_LO;
				T_LO: begin
					if (kind && nxt_idx != 5'(NWORDS)) begin
						st <= T_HI;
						widx <= nxt_idx;
					end else begin
						st <= T_TERM;
					end
				end
				default: st <= T_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy <= 1'b0;
			d2h_q <= 1'b1;
			tx_bit <= 4'h0;
			tx_cnt <= 16'h0;
			tx_sh <= 9'h1ff;
		end else if (!tx_busy) begin
			if (st != T_IDLE) begin
				tx_busy <= 1'b1;
				d2h_q <= 1'b0;
				tx_sh <= {1'b1, tx_byte};
				tx_bit <= 4'h0;
				tx_cnt <= FULL;
			end
		end else if (tx_cnt != 16'h0) begin
			tx_cnt <= tx_cnt - 16'h1;
		end else if (tx_bit == 4'h9) begin
			tx_busy <= 1'b0;
		end else begin
			d2h_q <= tx_sh[0];
			tx_sh <= {1'b1, tx_sh[8:1]};
			tx_bit <= tx_bit + 4'h1;
			tx_cnt <= FULL;
		end
	end

	assign link.d2h = d2h_q;
endmodule
`default_nettype wire

// ### rtl/iucp_host.sv
`timescale 1ns/1ps
`default_nettype none
module iucp_host #(
	parameter int POWERUP_CYC = iucp_pkg::POWER_UP_CYC,
	parameter int BIT_CYC = iucp_pkg::BIT_CYC_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	// Serial link
	iucp_link.host link
);
	import iucp_pkg::*;

	typedef enum logic [2:0] {
		H_WAIT = 3'b000,
		H_IDLE = 3'b001,
		H_GATE = 3'b011,
		H_SEND = 3'b010,
		H_REPLY = 3'b110
	} iucp_host_e;

	if (BIT_CYC < 4 || BIT_CYC > 65535 || POWERUP_CYC < 1) begin : g_chk
		$error("iucp_host: unsupported timing parameter");
	end

	localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
	localparam logic [15:0] HALF = 16'(BIT_CYC / 2 - 1);

	////////////////////////////////////////////////////////////////////////////
	logic [1:0] rx_meta;
	logic [2:0] dr_meta;
	logic rx_busy;
	logic rx_valid;
	logic [3:0] rx_bit;
	logic [15:0] rx_cnt;
	logic [7:0] rx_sh;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta <= 2'h3;
			dr_meta <= 3'h0;
		end else begin
			rx_meta <= {rx_meta[0], link.d2h};
			dr_meta <= {dr_meta[1:0], link.drdy};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_busy <= 1'b0;
			rx_valid <= 1'b0;
			rx_bit <= 4'h0;
			rx_cnt <= 16'h0;
			rx_sh <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_busy) begin
				if (!rx_meta[1]) begin
					rx_busy <= 1'b1;
					rx_cnt <= HALF;
					rx_bit <= 4'h0;
				end
			end else if (rx_cnt != 16'h0) begin
				rx_cnt <= rx_cnt - 16'h1;
			end else begin
				rx_cnt <= FULL;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0 && rx_meta[1]) begin
					rx_busy <= 1'b0;
				end else if (rx_bit == 4'h9) begin
					rx_busy <= 1'b0;
					rx_valid <= rx_meta[1];
				end else if (rx_bit != 4'h0) begin
					rx_sh <= {rx_meta[1], rx_sh[7:1]};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	iucp_host_e st;
	logic tx_busy;
	logic h2d_q;
	logic [1:0] bidx;
	logic [1:0] rcnt;
	logic [3:0] tx_bit;
	logic [15:0] tx_cnt;
	logic [8:0] tx_sh;
	logic [7:0] c_addr;
	logic [7:0] c_data;
	logic [15:0] rdata;
	logic [7:0] rxbyte;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic [31:0] pu_cnt;

	wire drdy_s = dr_meta[1];
	wire setup = psel && penable && !pready;
	wire wr_acc = psel && penable && pready && pwrite;
	wire cmd_wr = wr_acc && paddr == H_CMD && st == H_IDLE;
	wire [7:0] tx_byte = (bidx == 2'h0) ? c_addr : (bidx == 2'h1) ? c_data : TERM_BYTE;
	wire sent = st == H_SEND && !tx_busy && bidx == 2'h3;
	wire reply_end = st == H_REPLY && rx_valid && rcnt == 2'h3;
	wire ev_done = (sent && c_addr[7]) || reply_end;
	wire [2:0] events = {drdy_s && !dr_meta[2], rx_valid, ev_done};
	wire [2:0] w1c = (wr_acc && paddr == H_IRQ_STAT) ? pwdata[2:0] : 3'h0;
	wire mapped = paddr == H_CMD || paddr == H_STAT || paddr == H_RDATA ||
		paddr == H_RXBYTE || paddr == H_IRQ_STAT || paddr == H_IRQ_MASK;
	wire [31:0] rd_mux =
		(paddr == H_STAT) ? {29'h0, drdy_s, st != H_WAIT, st != H_IDLE} :
		(paddr == H_RDATA) ? {16'h0, rdata} :
		(paddr == H_RXBYTE) ? {24'h0, rxbyte} :
		(paddr == H_IRQ_STAT) ? {29'h0, irq_stat} :
		(paddr == H_IRQ_MASK) ? {29'h0, irq_mask} : 32'h0;

	// One wait state on every access so that read data comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			irq <= 1'b0;
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup) prdata <= rd_mux;
			// A new event wins over a clear in the same cycle
			irq_stat <= (irq_stat & ~w1c) | events;
			if (wr_acc && paddr == H_IRQ_MASK) irq_mask <= pwdata[2:0];
			irq <= |(irq_stat & irq_mask);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= H_WAIT;
			pu_cnt <= 32'h0;
			c_addr <= 8'h00;
			c_data <= 8'h00;
			rcnt <= 2'h0;
			rdata <= 16'h0000;
			rxbyte <= 8'h00;
		end else begin
			if (rx_valid) rxbyte <= rx_sh;
			case (st)
				H_WAIT: begin
					pu_cnt <= pu_cnt + 32'h1;
					if (pu_cnt >= 32'(POWERUP_CYC - 1)) st <= H_IDLE;
				end
				H_IDLE: begin
					if (cmd_wr) begin
						c_addr <= pwdata[7:0];
						c_data <= pwdata[15:8];
						st <= (pwdata[7:0] == BURST_CMD) ? H_GATE : H_SEND;
					end
				end
				H_GATE: if (drdy_s) st <= H_SEND;
				H_SEND: begin
					if (sent) st <= c_addr[7] ? H_IDLE : H_REPLY;
					rcnt <= 2'h0;
				end
				default: begin
					if (rx_valid) rcnt <= rcnt + 2'h1;
					if (rx_valid && rcnt == 2'h1) rdata[15:8] <= rx_sh;
					if (rx_valid && rcnt == 2'h2) rdata[7:0] <= rx_sh;
					if (reply_end) st <= H_IDLE;
				end
			endcase
		end
	end

	// Frame bytes: address, data, terminator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy <= 1'b0;
			h2d_q <= 1'b1;
			bidx <= 2'h0;
			tx_bit <= 4'h0;
			tx_cnt <= 16'h0;
			tx_sh <= 9'h1ff;
		end else if (!tx_busy) begin
			if (st != H_SEND) begin
				bidx <= 2'h0;
			end else if (bidx != 2'h3) begin
				tx_busy <= 1'b1;
				h2d_q <= 1'b0;
				tx_sh <= {1'b1, tx_byte};
				bidx <= bidx + 2'h1;
				tx_bit <= 4'h0;
				tx_cnt <= FULL;
			end
		end else if (tx_cnt != 16'h0) begin
			tx_cnt <= tx_cnt - 16'h1;
		end else if (tx_bit == 4'h9) begin
			tx_busy <= 1'b0;
		end else begin
			h2d_q <= tx_sh[0];
			tx_sh <= {1'b1, tx_sh[8:1]};
			tx_bit <= tx_bit + 4'h1;
			tx_cnt <= FULL;
		end
	end

	assign link.h2d = h2d_q;
endmodule
`default_nettype wire

// ### testbench/iucp_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module iucp_link_sva #(
	parameter int BIT_CYC = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link lines
	input wire logic h2d,
	input wire logic d2h,
	input wire logic drdy,
	// Device mode
	input wire logic sampling
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// Run length of each serial line (h2d, d2h) since its last change
	logic h_last;
	logic d_last;
	int h_run;
	int d_run;
	wire logic h_edge = h2d != h_last;
	wire logic d_edge = d2h != d_last;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			h_last <= 1'b1;
			d_last <= 1'b1;
			h_run <= 0;
			d_run <= 0;
		end else begin
			h_last <= h2d;
			d_last <= d2h;
			h_run <= h_edge ? 1 : h_run + 1;
			d_run <= d_edge ? 1 : d_run + 1;
		end
	end
	////////////////////////////////////////////////////////////////
	sequence s_reply_start;
		##[0:3] !d2h;
	endsequence
	sequence s_leave_sampling;
		$fell(sampling);
	endsequence
	// Start bit after a gap longer than any high run inside a frame
	// (eight one bits, stop bit and the idle cycle between bytes)
	sequence s_new_d2h_frame;
		d_edge && !d2h && d_run > 10 * BIT_CYC;
	endsequence
	AST_RST_LINES: assert property ($rose(presetn) |-> h2d && d2h)
		else $error("link lines not idle after reset");
	AST_RST_DRDY: assert property ($rose(presetn) |-> !drdy && !sampling)
		else $error("data ready or sampling high after reset");
	AST_H2D_BIT: assert property (h_edge |-> h_run >= BIT_CYC)
		else $error("host line bit shorter than a bit time");
	AST_D2H_BIT: assert property (d_edge |-> d_run >= BIT_CYC)
		else $error("device line bit shorter than a bit time");
	AST_D2H_ANSWER: assert property ((s_new_d2h_frame and !sampling) |-> h2d && h_run <= 2 * BIT_CYC)
		else $error("device frame not right after a host frame");
	AST_DRDY_SAMPLING: assert property ($rose(drdy) |-> sampling)
		else $error("data ready rose outside sampling");
	AST_DRDY_REPLY: assert property ($fell(drdy) && sampling && $past(sampling) |-> s_reply_start)
		else $error("data ready fell without a reply start");
	AST_DRDY_OFF: assert property (s_leave_sampling |-> ##[0:2] !drdy)
		else $error("data ready stays high in configuration");
endmodule
`default_nettype wire

// ### testbench/test_imu_uart_command_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_imu_uart_command_port;
	import iucp_pkg::*;
	localparam int BITC = 8;
	localparam int SAMP = 4000;
	localparam int LIMIT = 95000;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	wire logic [31:0] prdata;
	wire logic pready;
	wire logic pslverr;
	wire logic irq;
	wire logic sampling;
	logic [NWORDS-1:0][15:0] sw;
	logic [1:0] hw_fault = 2'b10;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int quiet;
	int t0;
	logic [31:0] r;
	logic perr;
	logic [7:0] b;
	logic [7:0] exp_q [$];
	// Ordinary register traffic: first byte, second byte, expected read value
	logic [31:0] rows [17] = '{32'hfe00_0000, 32'h0200_0400, 32'h0400_0040, 32'h8301_0000,
		32'h0200_0000, 32'h8302_0000, 32'h0200_0400, 32'hfe01_0000, 32'h0400_0000,
		32'h8c06_0000, 32'h8df0_0000, 32'h8f70_0000, 32'h0c00_f006, 32'h0e00_7000,
		32'h0800_0000, 32'h0200_0000, 32'hfe00_0000};
	iucp_link link();
	iucp_host #(.POWERUP_CYC(200), .BIT_CYC(BITC)) i_iucp_host (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
	iucp_device #(.STARTUP_CYC(1500), .SAMPLE_CYC(SAMP), .BIT_CYC(BITC)) i_iucp_device (
		.pclk(pclk), .presetn(presetn), .link(link), .sample_words(sw), .hw_fault(hw_fault),
		.sampling(sampling));
	iucp_link_sva #(.BIT_CYC(BITC)) i_iucp_link_sva (.pclk(pclk), .presetn(presetn),
		.h2d(link.h2d), .d2h(link.d2h), .drdy(link.drdy), .sampling(sampling));
	always #10 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			bad_count++;
			$display("[ERR] %0t run did not finish", $time);
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until pready is seen high; data taken at that edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic idle();
		do apb(H_STAT, 1'b0, 32'h0); while (r[0] !== 1'b0);
	endtask
	task automatic cmd(input logic [7:0] b0, input logic [7:0] b1);
		apb(H_CMD, 1'b1, {16'h0, b1, b0});
	endtask
	task automatic wr_cmd(input logic [7:0] b0, input logic [7:0] b1);
		cmd(b0, b1);
		idle();
	endtask
	// Sniffs the device line mid-bit and compares against the queue
	task automatic rx_chk();
		foreach (exp_q[k]) begin
			while (link.d2h !== 1'b0) @(negedge pclk);
			repeat (BITC / 2) @(negedge pclk);
			for (int j = 0; j < 8; j++) begin
				repeat (BITC) @(negedge pclk);
				b[j] = link.d2h;
			end
			repeat (BITC) @(negedge pclk);
			chk({23'h0, link.d2h, b}, {24'h1, exp_q[k]});
		end
		exp_q = {};
	endtask
	task automatic frame(input logic w32);
		exp_q = '{BURST_CMD};
		for (int i = 0; i < NWORDS; i++) begin
			if (w32 || !(i >= 2 && i <= 14 && i % 2 == 0)) begin
				exp_q.push_back(sw[i][15:8]);
				exp_q.push_back(sw[i][7:0]);
			end
		end
		exp_q.push_back(TERM_BYTE);
	endtask
	task automatic burst(input logic w32);
		frame(w32);
		cmd(BURST_CMD, 8'h00);
		rx_chk();
		idle();
	endtask
	task automatic rd_reg(input logic [7:0] a);
		cmd(a, 8'h00);
		idle();
		apb(H_RDATA, 1'b0, 32'h0);
	endtask
	task automatic do_row(input logic [31:0] row);
		cmd(row[31:24], row[23:16]);
		if (!row[31]) begin
			exp_q = '{row[31:24], row[15:8], row[7:0], TERM_BYTE};
			rx_chk();
			idle();
			apb(H_RDATA, 1'b0, 32'h0);
			chk(r, {16'h0, row[15:0]});
		end else begin
			idle();
			quiet = 0;
			repeat (100) @(negedge pclk) quiet += (link.d2h !== 1'b1);
			chk(quiet, 0);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < NWORDS; i++) sw[i] = 16'h5a00 + 16'(i * 17);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk({link.h2d, link.d2h, link.drdy, sampling, irq, pready}, 6'b110000);
		apb(H_STAT, 1'b0, 32'h0);
		chk(r[1:0], 2'b01);
		cmd(WIN_SEL, 8'h01);
		quiet = 0;
		repeat (150) @(negedge pclk) quiet += (link.h2d !== 1'b1);
		chk(quiet, 0);
		do apb(H_STAT, 1'b0, 32'h0); while (r[1] !== 1'b1);
		wr_cmd(WIN_SEL, 8'h01);
		rd_reg(8'h0a);
		chk(r, 32'h0400);
		while (r[10] !== 1'b0) rd_reg(8'h0a);
		chk(r, 32'h0);
		foreach (rows[k]) begin
			do_row(rows[k]);
			if (rows[k][31:24] == 8'h83) chk(sampling, rows[k][16]);
		end
		// Fault field clear reads as normal operation
		@(posedge pclk);
		hw_fault <= 2'b00;
		rd_reg(8'h04);
		chk(r, 32'h0);
		apb(H_RXBYTE, 1'b0, 32'h0);
		chk(r, {24'h0, TERM_BYTE});
		wr_cmd(8'h83, MODE_GO_SAMPLE);
		burst(1'b1);
		wr_cmd(WIN_SEL, 8'h01);
		wr_cmd(8'h8f, 8'h00);
		wr_cmd(WIN_SEL, 8'h00);
		burst(1'b0);
		apb(H_IRQ_STAT, 1'b1, 32'h7);
		apb(H_IRQ_MASK, 1'b1, 32'h1);
		repeat (2) @(negedge pclk);
		chk(irq, 1'b0);
		wr_cmd(WIN_SEL, 8'h00);
		repeat (2) @(negedge pclk);
		chk(irq, 1'b1);
		apb(H_IRQ_STAT, 1'b1, 32'h1);
		repeat (2) @(negedge pclk);
		chk(irq, 1'b0);
		apb(H_IRQ_MASK, 1'b1, 32'h0);
		wr_cmd(WIN_SEL, 8'h00);
		apb(H_IRQ_STAT, 1'b0, 32'h0);
		chk({r[0], irq}, 2'b10);
		apb(12'h018, 1'b0, 32'h0);
		chk({perr, r}, {1'b1, 32'h0});
		wr_cmd(8'h83, MODE_GO_CFG);
		wr_cmd(WIN_SEL, 8'h01);
		wr_cmd(8'h88, 8'h01);
		wr_cmd(WIN_SEL, 8'h00);
		wr_cmd(8'h83, MODE_GO_SAMPLE);
		frame(1'b0);
		rx_chk();
		t0 = cyc;
		frame(1'b0);
		rx_chk();
		chk(cyc - t0 >= SAMP - 4 && cyc - t0 <= SAMP + 4, 1'b1);
		// Reset lands on the start bit of an automatic frame
		while (link.d2h !== 1'b0) @(negedge pclk);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(negedge pclk);
		chk({link.h2d, link.d2h, link.drdy, sampling, irq}, 5'b11000);
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		test_done();
	end
endmodule
`default_nettype wire
